/* File: logic/sciomd_top.sv */
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

// Notes on behaviour
// - Auto-enable set: low clear-to-send enables that channel's transmitter; here only with its transmit-enable bit also set.
// - Auto-enable clear: clear-to-send is only a readable input.
// - Clear-to-send edges, both directions, can raise an interrupt.
// - Auto-enable set: low carrier-detect enables that channel's receiver.
// - Auto-enable clear: carrier-detect is only a readable input.
// - Carrier-detect edges, both directions, can raise an interrupt.
// - Terminal-ready output, active low, follows its control bit.
// - Terminal-ready output may instead carry a DMA request.
// - Chain output high only with chain input high, not serviced, not requesting in acknowledge.
// - Low chain output blocks all downstream interrupts.
// - Open-drain interrupt request pulled low while an interrupt is pending and not yet in service.
// - Acknowledge low marks acknowledge cycle; chain priority settles then.
// - In acknowledge, read strobe with chain input high and an interrupt pending drives the vector.
// - Acknowledge input sampled on the rising clock edge.
// - Inputs synchronised to the single master clock.
// - Transmit bit rate never exceeds a quarter of the clock.
module sciomd_top
   import sciomd_pkg::*;
(
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          clk_en,
   // Register port
   input  wire logic [3:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [7:0]    reg_rdata,
   // Modem lines, two channels
   input  sciomd_modem_s [1:0] modem_in,
   output logic      [1:0]    term_ready_n,
   output logic      [1:0]    tx_enable,
   output logic      [1:0]    rx_enable,
   output logic      [1:0]    tx_bit_tick,
   // DMA request sources from the data path
   input  wire logic [1:0]    dma_req,
   // Daisy chain
   input  wire logic          chain_enable_in,
   output logic               chain_enable_out,
   input  wire logic          irq_acknowledge_n,
   input  wire logic          bus_rd_n,
   output logic      [7:0]    vec_out,
   output logic               vec_oe_n,
   output logic               irq_req_out,
   output logic               irq_req_oe_n,
   // Local level interrupt
   output logic               irq
);

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic [3:0] pin_d_reg;
   logic [2:0] ack_s1_reg;
   logic [2:0] ack_s2_reg;
   logic [3:0] pin_raw;

   assign pin_raw = {modem_in[1].dcd_n, modem_in[1].cts_n, modem_in[0].dcd_n, modem_in[0].cts_n};

   // Two stages for every pin; first stage feeds only the second
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_reg <= 4'hF;
         pin_s2_reg <= 4'hF;
         pin_d_reg  <= 4'hF;
      end else if (clk_en) begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_d_reg  <= pin_s2_reg;
      end
   end

   // Chain, acknowledge and read strobe sampled on the rising edge
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_s1_reg <= 3'h3;
         ack_s2_reg <= 3'h3;
      end else if (clk_en) begin
         ack_s1_reg <= {chain_enable_in, bus_rd_n, irq_acknowledge_n};
         ack_s2_reg <= ack_s1_reg;
      end
   end

   logic ack_act;
   logic rd_act;
   logic cei;
   assign ack_act = ~ack_s2_reg[0];
   assign rd_act  = ~ack_s2_reg[1];
   assign cei     = ack_s2_reg[2];

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl_reg;
   logic [7:0] vector_reg;
   logic [3:0] irq_st_reg;
   logic [3:0] irq_en_reg;
   logic       in_service_reg;
   logic       wr_ctrl;
   logic       wr_clr;

   assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
   assign wr_clr  = reg_wr && reg_addr == ADDR_IRQ_CLR;

   // Software-written configuration
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg   <= CTRL_RST;
         vector_reg <= VECTOR_RST;
         irq_en_reg <= IRQ_EN_RST;
      end else if (clk_en && reg_wr) begin
         if (wr_ctrl)                 ctrl_reg   <= reg_wdata;
         if (reg_addr == ADDR_VECTOR) vector_reg <= reg_wdata;
         if (reg_addr == ADDR_IRQ_EN) irq_en_reg <= reg_wdata[3:0];
      end
   end

   function automatic logic ctl_bit(input logic [7:0] c, input int ch, input int f);
      ctl_bit = c[ch * CTL_CH_W + f];
   endfunction

   // ---------------------------------------------------------------
   // Edge events, sticky; a set in the clear cycle survives
   // ---------------------------------------------------------------
   logic [3:0] edge_ev;
   assign edge_ev = pin_s2_reg ^ pin_d_reg;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_st_reg <= 4'h0;
      end else if (clk_en) begin
         irq_st_reg <= (irq_st_reg & ~(wr_clr ? reg_wdata[3:0] : 4'h0)) | edge_ev;
      end
   end

   logic pending;
   assign pending = |(irq_st_reg & irq_en_reg);
   assign irq     = pending;

   // ---------------------------------------------------------------
   // Daisy chain: service begins on vector read, ends on pending clear
   // ---------------------------------------------------------------
   logic ack_rd_d_reg;
   logic vec_take;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_rd_d_reg <= 1'b0;
      end else if (clk_en) begin
         ack_rd_d_reg <= ack_act && rd_act;
      end
   end
   assign vec_take = ack_act && rd_act && !ack_rd_d_reg && cei && pending;

   // Service held until software clears all enabled status
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_service_reg <= 1'b0;
      end else if (clk_en) begin
         if (vec_take)
            in_service_reg <= 1'b1;
         else if (!pending)
            in_service_reg <= 1'b0;
      end
   end

   // Chain output and request pin, registered for clean pins
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         chain_enable_out <= 1'b0;
         irq_req_oe_n     <= 1'b1;
         vec_out          <= 8'h00;
         vec_oe_n         <= 1'b1;
      end else if (clk_en) begin
         chain_enable_out <= cei && !in_service_reg && !(ack_act && pending);
         irq_req_oe_n     <= !(pending && !in_service_reg);
         vec_out          <= vector_reg;
         vec_oe_n         <= !(ack_act && rd_act && cei && pending);
      end
   end
   assign irq_req_out = 1'b0;

   // ---------------------------------------------------------------
   // Modem control per channel
   // ---------------------------------------------------------------
   logic [2:0] tick_cnt_reg [2];

   // Auto-enable gates tx/rx; one process owns both channels' bits
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_enable    <= 2'h0;
         rx_enable    <= 2'h0;
         term_ready_n <= 2'h3;
      end else if (clk_en) begin
         for (int c = 0; c < 2; c++) begin
            if (ctl_bit(ctrl_reg, c, CTL_AUTO)) begin
               tx_enable[c] <= ctl_bit(ctrl_reg, c, CTL_TXEN) && !pin_s2_reg[2*c + EV_CTS];
               rx_enable[c] <= !pin_s2_reg[2*c + EV_DCD];
            end else begin
               tx_enable[c] <= ctl_bit(ctrl_reg, c, CTL_TXEN);
               rx_enable[c] <= 1'b1;
            end
            if (ctl_bit(ctrl_reg, c, CTL_REQS))
               term_ready_n[c] <= !dma_req[c];
            else
               term_ready_n[c] <= !ctl_bit(ctrl_reg, c, CTL_TR);
         end
      end
   end

   // Bit tick at most every fourth clock; restarts whenever tx drops
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_reg[0] <= 3'h0;
         tick_cnt_reg[1] <= 3'h0;
         tx_bit_tick     <= 2'h0;
      end else if (clk_en) begin
         for (int c = 0; c < 2; c++) begin
            tx_bit_tick[c] <= 1'b0;
            if (!tx_enable[c])
               tick_cnt_reg[c] <= 3'h0;
            else if (tick_cnt_reg[c] == 3'(TX_DIV_MIN - 1)) begin
               tick_cnt_reg[c] <= 3'h0;
               tx_bit_tick[c]  <= 1'b1;
            end else
               tick_cnt_reg[c] <= tick_cnt_reg[c] + 3'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            unique case (reg_addr)
               ADDR_CTRL:   reg_rdata <= ctrl_reg;
               ADDR_STAT:   reg_rdata <= {2'h0, tx_enable, pin_s2_reg};
               ADDR_IRQ_ST: reg_rdata <= {4'h0, irq_st_reg};
               ADDR_IRQ_EN: reg_rdata <= {4'h0, irq_en_reg};
               ADDR_VECTOR: reg_rdata <= vector_reg;
               ADDR_PEND:   reg_rdata <= {6'h00, in_service_reg, pending};
               default:     reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_chain_block;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && in_service_reg |=> !chain_enable_out;
   endproperty
   a_chain_block: assert property (p_chain_block) else $error("chain out high while serviced");

   property p_chain_need_in;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !cei |=> !chain_enable_out;
   endproperty
   a_chain_need_in: assert property (p_chain_need_in) else $error("chain out high with chain in low");

   property p_irq_pin;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && pending && !in_service_reg |=> !irq_req_oe_n;
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("request pin not pulled");

   property p_vec_drive;
      @(posedge sys_clk) disable iff (sys_rst)
      !vec_oe_n |-> $past(ack_act) && $past(cei) && $past(rd_act);
   endproperty
   a_vec_drive: assert property (p_vec_drive) else $error("vector driven outside acknowledge");

   property p_edge_sets;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && edge_ev[0] |=> irq_st_reg[0];
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("cts edge lost");

   property p_dcd_sets;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && edge_ev[1] |=> irq_st_reg[1];
   endproperty
   a_dcd_sets: assert property (p_dcd_sets) else $error("dcd edge lost");

   property p_tick_gap;
      @(posedge sys_clk) disable iff (sys_rst)
      tx_bit_tick[0] |=> !tx_bit_tick[0] [*3];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("bit tick faster than quarter clock");

   property p_auto_tx;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && ctrl_reg[CTL_AUTO] && pin_s2_reg[0] |=> !tx_enable[0];
   endproperty
   a_auto_tx: assert property (p_auto_tx) else $error("tx enabled with cts high");

   property p_dtr;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !ctrl_reg[CTL_REQS] |=> term_ready_n[0] == !$past(ctrl_reg[CTL_TR]);
   endproperty
   a_dtr: assert property (p_dtr) else $error("terminal ready mismatch");

   property p_auto_rx;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && ctrl_reg[CTL_AUTO] |=> rx_enable[0] == !$past(pin_s2_reg[EV_DCD]);
   endproperty
   a_auto_rx: assert property (p_auto_rx) else $error("rx enable does not follow carrier detect");

   property p_manual_rx;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !ctrl_reg[CTL_AUTO] |=> rx_enable[0];
   endproperty
   a_manual_rx: assert property (p_manual_rx) else $error("rx gated without auto-enable");

   property p_manual_tx;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !ctrl_reg[CTL_AUTO] |=> tx_enable[0] == $past(ctrl_reg[CTL_TXEN]);
   endproperty
   a_manual_tx: assert property (p_manual_tx) else $error("tx enable ignores its control bit");

   property p_dma_req;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && ctrl_reg[CTL_REQS] |=> term_ready_n[0] == !$past(dma_req[0]);
   endproperty
   a_dma_req: assert property (p_dma_req) else $error("request line does not follow dma request");

   property p_chain_ack;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && ack_act && pending |=> !chain_enable_out;
   endproperty
   a_chain_ack: assert property (p_chain_ack) else $error("chain out high while requesting in acknowledge");

   property p_chain_open;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && cei && !in_service_reg && !ack_act |=> chain_enable_out;
   endproperty
   a_chain_open: assert property (p_chain_open) else $error("chain out held low with nothing to block");

   property p_vec_take;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && vec_take |=> in_service_reg && !vec_oe_n;
   endproperty
   a_vec_take: assert property (p_vec_take) else $error("acknowledge did not start service");

   property p_req_release;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !pending |=> irq_req_oe_n;
   endproperty
   a_req_release: assert property (p_req_release) else $error("request pin pulled with nothing pending");

   property p_tick_off;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && !tx_enable[0] |=> !tx_bit_tick[0];
   endproperty
   a_tick_off: assert property (p_tick_off) else $error("bit tick with transmitter off");

   property p_clear_works;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && wr_clr && reg_wdata[EV_CTS] && !edge_ev[EV_CTS] |=> !irq_st_reg[EV_CTS];
   endproperty
   a_clear_works: assert property (p_clear_works) else $error("status clear had no effect");

endmodule

/* File: logic/sciomd_pkg.sv */
package sciomd_pkg;

   // ---------------------------------------------------------------
   // Register map (word index = byte address / 4)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_STAT    = 4'h1;
   localparam logic [3:0] ADDR_IRQ_ST  = 4'h2;
   localparam logic [3:0] ADDR_IRQ_EN  = 4'h3;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
   localparam logic [3:0] ADDR_VECTOR  = 4'h5;
   localparam logic [3:0] ADDR_PEND    = 4'h6;

   // ---------------------------------------------------------------
   // Control register fields, per channel c: bit base 4*c
   // ---------------------------------------------------------------
   localparam int CTL_AUTO  = 0;
   localparam int CTL_TR    = 1;
   localparam int CTL_REQS  = 2;
   localparam int CTL_TXEN  = 3;
   localparam int CTL_CH_W  = 4;

   // Event bits per channel c: base 2*c (cts change, dcd change)
   localparam int EV_CTS    = 0;
   localparam int EV_DCD    = 1;

   localparam logic [7:0] CTRL_RST   = 8'h22;
   localparam logic [7:0] VECTOR_RST = 8'h00;
   localparam logic [3:0] IRQ_EN_RST = 4'h0;

   // Bit rate ceiling: one bit per this many clocks at least
   localparam int TX_DIV_MIN = 4;

   // Modem pins of one channel
   typedef struct packed {
      logic cts_n;
      logic dcd_n;
   } sciomd_modem_s;

endpackage

/* File: verification/sciomd_host_model.sv */
`timescale 1ns/1ps

// Host and upstream neighbour seen from the device pins
module sciomd_host_model (
   // Clock
   input  wire logic sys_clk,
   // Commands from the bench
   input  wire logic ack_go,
   input  wire logic upstream_free,
   // Pins toward the device
   output logic      chain_enable_in,
   output logic      irq_acknowledge_n,
   output logic      bus_rd_n
);
   int hold = 0;

   // Upstream frees the chain only when nothing above is pending
   assign chain_enable_in = upstream_free;

   // Acknowledge cycle: both strobes held low together for eight clocks
   always @(posedge sys_clk) begin
      if (ack_go)
         hold <= 8;
      else if (hold > 0)
         hold <= hold - 1;
   end

   // Released strobes go back high, as a pull-up would take them
   assign irq_acknowledge_n = !(hold > 0);
   assign bus_rd_n          = !(hold > 0);
endmodule

/* File: verification/test_serial_ctrl_irq_chain_modem_io.sv */
`timescale 1ns/1ps

module test_serial_ctrl_irq_chain_modem_io;
   import sciomd_pkg::*;
   logic sys_clk = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, go = 0, up = 0;
   logic [3:0] reg_addr = 4'h0, pv = 4'hF;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, vec_out, ctrl = 8'h22, vec, seen_vec;
   logic [7:0] modes [6] = '{8'h00, 8'h88, 8'h11, 8'h99, 8'h44, 8'h22};
   sciomd_modem_s [1:0] modem_in = '1;
   logic [1:0] term_ready_n, tx_enable, rx_enable, tx_bit_tick, dma_req = 2'h0;
   logic chain_enable_in, chain_enable_out, irq_acknowledge_n, bus_rd_n;
   logic vec_oe_n, irq_req_out, irq_req_oe_n, irq, seen_oe = 0;
   int n_fail = 0, comparisons = 0, cyc = 0, ticks = 0;

   sciomd_top uut (.sys_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .modem_in, .term_ready_n, .tx_enable, .rx_enable, .tx_bit_tick, .dma_req,
      .chain_enable_in, .chain_enable_out, .irq_acknowledge_n, .bus_rd_n, .vec_out,
      .vec_oe_n, .irq_req_out, .irq_req_oe_n, .irq);
   sciomd_host_model host (.sys_clk, .ack_go(go), .upstream_free(up), .chain_enable_in,
      .irq_acknowledge_n, .bus_rd_n);

   // ----------------------------------------
   // Clock, hang guard and vector monitor
   // ----------------------------------------
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
      if (vec_oe_n === 1'b0) begin
         seen_oe <= 1'b1;
         seen_vec <= vec_out;
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk8(reg_rdata, exp);
   endtask
   // Pins in event-bit order: cts0, dcd0, cts1, dcd1
   task automatic pins(input logic [3:0] v);
      @(posedge sys_clk);
      modem_in[0].cts_n <= v[0];
      modem_in[0].dcd_n <= v[1];
      modem_in[1].cts_n <= v[2];
      modem_in[1].dcd_n <= v[3];
      pv = v;
      wt(8);
   endtask
   task automatic modem_chk();
      logic [1:0] etx, erx, etr;
      for (int c = 0; c < 2; c++) begin
         etx[c] = ctrl[4*c+CTL_TXEN] && !(ctrl[4*c+CTL_AUTO] && pv[2*c]);
         erx[c] = ctrl[4*c+CTL_AUTO] ? !pv[2*c+1] : 1'b1;
         etr[c] = ctrl[4*c+CTL_REQS] ? !dma_req[c] : !ctrl[4*c+CTL_TR];
      end
      rd(ADDR_STAT, {2'b00, etx, pv});
      chk8({2'b00, tx_enable, 2'b00, rx_enable}, {2'b00, etx, 2'b00, erx});
      chk8({6'h00, term_ready_n}, {6'h00, etr});
   endtask
   task automatic ack_cycle();
      seen_oe = 1'b0;
      @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      wt(12);
   endtask

   initial begin
      void'($urandom(32'h9127));
      wt(4);
      sys_rst <= 1'b0;
      rd(ADDR_CTRL, CTRL_RST);
      rd(4'hF, 8'h00);
      modem_chk();
      // Every mode against random pins and DMA requests
      foreach (modes[m]) begin
         ctrl = modes[m];
         wr(ADDR_CTRL, ctrl);
         for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            dma_req <= 2'($urandom);
            pins(4'($urandom));
            modem_chk();
         end
      end
      // Each modem line interrupts on both edges
      pins(4'hF);
      wr(ADDR_IRQ_CLR, 8'hFF);
      wr(ADDR_IRQ_EN, 8'h0F);
      for (int b = 0; b < 8; b++) begin
         pins(pv ^ (4'h1 << (b / 2)));
         rd(ADDR_IRQ_ST, 8'h01 << (b / 2));
         chk8({5'h00, irq_req_out, irq, irq_req_oe_n}, 8'h02);
         wr(ADDR_IRQ_CLR, 8'h0F);
         rd(ADDR_IRQ_ST, 8'h00);
      end
      // Masked events stay silent
      wr(ADDR_IRQ_EN, 8'h00);
      pins(pv ^ 4'h1);
      chk8({6'h00, irq, irq_req_oe_n}, 8'h01);
      // Acknowledge blocked upstream, then granted
      vec = 8'($urandom);
      wr(ADDR_VECTOR, vec);
      wr(ADDR_IRQ_EN, 8'h01);
      ack_cycle();
      chk8({7'h00, seen_oe}, 8'h00);
      chk8({7'h00, chain_enable_out}, 8'h00);
      up <= 1'b1;
      wt(6);
      chk8({7'h00, chain_enable_out}, 8'h01);
      ack_cycle();
      chk8({6'h00, seen_oe, chain_enable_out}, 8'h02);
      chk8(seen_vec, vec);
      chk8({7'h00, irq_req_oe_n}, 8'h01);
      wr(ADDR_IRQ_CLR, 8'h0F);
      wt(6);
      chk8({7'h00, chain_enable_out}, 8'h01);
      // Clock enable low: a write must not land
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(ADDR_VECTOR, ~vec);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(ADDR_VECTOR, vec);
      // Transmit ticks no faster than a quarter clock
      ctrl = 8'h08;
      wr(ADDR_CTRL, ctrl);
      wt(4);
      repeat (40) begin
         @(negedge sys_clk);
         if (tx_bit_tick[0] === 1'b1)
            ticks++;
      end
      chk8(8'(ticks), 8'h0A);
      // Reset in mid-run returns the terminal-ready, tx/rx enable, chain, irq and output-enable pins to their reset levels
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      wt(2);
      chk8({2'h0, term_ready_n, tx_enable, rx_enable}, 8'h30);
      chk8({4'h0, vec_oe_n, irq_req_oe_n, chain_enable_out, irq}, 8'h0C);
      sys_rst <= 1'b0;
      ctrl = CTRL_RST;
      rd(ADDR_CTRL, CTRL_RST);
      modem_chk();
      chk8({7'h00, chain_enable_out}, 8'h01);
      end_sim();
   end
endmodule
